// ==== logic/query_pkg.sv ====
// Purpose: Shared constants and types for the flash query space block
// Assumes: Query entries are word wide, one per APB word
// Notes:   Entry offsets are relative to the pointer held at the pointer location
package query_pkg;

  localparam int IDX_W  = 10;
  localparam int WORD_W = 16;
  localparam int NUM_ENT = 21;

  // Pointer location and the pointer it holds
  localparam logic [IDX_W-1:0]  PTR_LOC = 10'h015;
  localparam logic [WORD_W-1:0] PTR_VAL = 16'h010A;

  // Entry displacements from the pointer, in address order
  localparam logic [NUM_ENT-1:0][7:0] ENT_DELTA = {
    8'h31, 8'h30, 8'h2F, 8'h2E, 8'h2D, 8'h2C, 8'h2B, 8'h2A, 8'h29, 8'h28, 8'h27,
    8'h26, 8'h25, 8'h24, 8'h23, 8'h22, 8'h21, 8'h20, 8'h1F, 8'h1E, 8'h1D};

  localparam logic [NUM_ENT-1:0][WORD_W-1:0] ENT_DATA = {
    16'h0003, 16'h0001, 16'h0000, 16'h0064, 16'h0002, 16'h0000, 16'h0000,
    16'h0007, 16'h0001, 16'h0000, 16'h0000, 16'h0011, 16'h0000, 16'h000F,
    16'h0002, 16'h0007, 16'h0003, 16'h0002, 16'h0001, 16'h0004, 16'h0003};

  // Displacements named for checking
  localparam logic [7:0] D_PAGE    = 8'h1D;
  localparam logic [7:0] D_SYNCNUM = 8'h1E;
  localparam logic [7:0] D_SYNC1   = 8'h1F;
  localparam logic [7:0] D_BANKNUM = 8'h23;
  localparam logic [7:0] D_BANKCNT = 8'h24;
  localparam logic [7:0] D_CONC    = 8'h26;
  localparam logic [7:0] D_OTHPRG  = 8'h27;
  localparam logic [7:0] D_OTHERS  = 8'h28;
  localparam logic [7:0] D_BLKTYP  = 8'h29;
  localparam logic [7:0] D_BLKDSC  = 8'h2A;
  localparam logic [7:0] D_ENDUR   = 8'h2E;
  localparam logic [7:0] D_CELL    = 8'h30;
  localparam logic [7:0] D_MODE    = 8'h31;

  // Own registers, word indices
  localparam logic [IDX_W-1:0] IDX_CTRL   = 10'h1F0;
  localparam logic [IDX_W-1:0] IDX_RDCFG  = 10'h1F1;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h1F2;

  localparam int          CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
  localparam logic [2:0]  RDCFG_RST   = 3'h7;
  localparam logic [2:0]  BURST_CONT  = 3'h7;
  localparam int          ST_CNT_LSB  = 0;
  localparam int          ST_CONT_BIT = 16;
  localparam int          ST_LEN_LSB  = 17;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

endpackage : query_pkg

// ==== logic/query_rom.sv ====
// Purpose: Constant query table with registered read data
// Assumes: Index is a word index into the query space
// Notes:   Misses read as zero with hit low
module query_rom #(
  parameter int IDX_W  = query_pkg::IDX_W,
  parameter int WORD_W = query_pkg::WORD_W
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              rd_en_in,
  input  wire logic [IDX_W-1:0]  rd_idx_in,
  output logic      [WORD_W-1:0] rd_data_out,
  output logic                   rd_hit_out
);

  logic [query_pkg::NUM_ENT-1:0] hit;
  logic [WORD_W-1:0]             data_d;
  logic                          hit_d;

  for (genvar i = 0; i < query_pkg::NUM_ENT; i++) begin : g_ent
    assign hit[i] = (rd_idx_in == IDX_W'(query_pkg::PTR_VAL)
                     + IDX_W'(query_pkg::ENT_DELTA[i]));
  end

  always_comb begin
    data_d = '0;
    hit_d  = 1'b0;
    for (int i = 0; i < query_pkg::NUM_ENT; i++) begin
      if (hit[i]) begin
        data_d = data_d | query_pkg::ENT_DATA[i];
        hit_d  = 1'b1;
      end
    end
    if (rd_idx_in == query_pkg::PTR_LOC) begin
      data_d = query_pkg::PTR_VAL;
      hit_d  = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
      rd_hit_out  <= 1'b0;
    end else if (rd_en_in) begin
      rd_data_out <= data_d;
      rd_hit_out  <= hit_d;
    end
  end

endmodule // query_rom

// ==== logic/query_space.sv ====
// Purpose: APB slave exposing the burst and bank region 1 query entries
// Assumes: APB master on the same clock; one wait state per transfer
// Notes:   Query words sit at byte address four times their query offset
module query_space (
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT
);

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_ANSWER} state_t;

  query_pkg::apb_req_t               req;
  state_t                            state_q;
  logic [query_pkg::IDX_W-1:0]       idx;
  logic [query_pkg::IDX_W-1:0]       idx_q;
  logic                              write_q;
  logic                              setup;
  logic                              wr_ok_q;
  logic [query_pkg::WORD_W-1:0]      rom_data;
  logic                              rom_hit;
  logic [31:0]                       ctrl_q;
  logic [2:0]                        rdcfg_q;
  logic [15:0]                       rd_cnt_q;
  logic                              cont_q;
  logic [7:0]                        len_q;
  logic [31:0]                       status;
  logic [31:0]                       rdata_d;
  logic                              err_d;
  logic                              qry_ok_d;
  logic                              qry_ok_q;

  assign req    = '{sel: PSEL_IN, enable: PENABLE_IN, write: PWRITE_IN,
                    addr: PADDR_IN, wdata: PWDATA_IN};
  assign setup  = req.sel && !req.enable;
  assign idx    = req.addr[11:2];

  // Table lookup starts on the setup cycle so the answer needs one wait state
  query_rom #(
    .IDX_W  (query_pkg::IDX_W),
    .WORD_W (query_pkg::WORD_W)
  ) u_rom (
    .clk_in      (CLOCK_IN),
    .rst_in      (RST_IN),
    .rd_en_in    (setup && !req.write),
    .rd_idx_in   (idx),
    .rd_data_out (rom_data),
    .rd_hit_out  (rom_hit)
  );

  assign status = {7'h00, len_q, cont_q, rd_cnt_q};

  // Decode of the latched request
  always_comb begin
    rdata_d  = '0;
    err_d    = 1'b0;
    qry_ok_d = 1'b0;
    case (idx_q)
      query_pkg::IDX_CTRL:   rdata_d = ctrl_q;
      query_pkg::IDX_RDCFG:  rdata_d = {29'h0, rdcfg_q};
      query_pkg::IDX_STATUS: begin
        rdata_d = status;
        err_d   = write_q;
      end
      default: begin
        if (write_q || !rom_hit || !ctrl_q[query_pkg::CTRL_EN_BIT]) begin
          err_d = 1'b1;
        end else begin
          rdata_d  = {16'h0000, rom_data};
          qry_ok_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      state_q     <= ST_IDLE;
      idx_q       <= '0;
      write_q     <= 1'b0;
      wr_ok_q     <= 1'b0;
      qry_ok_q    <= 1'b0;
      PRDATA_OUT  <= '0;
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (setup) begin
            idx_q   <= idx;
            write_q <= req.write;
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          PRDATA_OUT  <= write_q ? 32'h0000_0000 : rdata_d;
          PSLVERR_OUT <= err_d;
          PREADY_OUT  <= 1'b1;
          wr_ok_q     <= write_q && !err_d;
          qry_ok_q    <= qry_ok_d;
          state_q     <= ST_ANSWER;
        end
        ST_ANSWER: begin
          PREADY_OUT  <= 1'b0;
          PSLVERR_OUT <= 1'b0;
          PRDATA_OUT  <= '0;
          wr_ok_q     <= 1'b0;
          qry_ok_q    <= 1'b0;
          state_q     <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Writes land on the edge that completes the access
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      ctrl_q <= query_pkg::CTRL_RST;
    end else if (wr_ok_q && req.sel && req.enable && idx_q == query_pkg::IDX_CTRL) begin
      ctrl_q <= {31'h0, req.wdata[query_pkg::CTRL_EN_BIT]};
    end
  end

  // host copies a code into bits 0-2
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      rdcfg_q <= query_pkg::RDCFG_RST;
    end else if (wr_ok_q && req.sel && req.enable && idx_q == query_pkg::IDX_RDCFG) begin
      rdcfg_q <= req.wdata[2:0];
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      cont_q <= 1'b1;
      len_q  <= '0;
    end else begin
      cont_q <= (rdcfg_q == query_pkg::BURST_CONT);
      len_q  <= (rdcfg_q == query_pkg::BURST_CONT) ? 8'h00 : 8'h02 << rdcfg_q;
    end
  end

  // Counts query reads, saturating so software never sees a wrap
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      rd_cnt_q <= '0;
    end else if (qry_ok_q && req.sel && req.enable && rd_cnt_q != 16'hFFFF) begin
      rd_cnt_q <= 16'(rd_cnt_q + 16'h0001);
    end
  end

  // Checks
  sequence s_rd_setup(logic [9:0] a);
    PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN[11:2] == a
      && ctrl_q[query_pkg::CTRL_EN_BIT] && state_q == ST_IDLE;
  endsequence

  sequence s_answer(logic [15:0] v);
    PREADY_OUT && !PSLVERR_OUT && PRDATA_OUT == {16'h0000, v};
  endsequence

  property p_entry(logic [7:0] d, logic [15:0] v);
    @(posedge CLOCK_IN) disable iff (RST_IN)
      s_rd_setup(10'(query_pkg::PTR_VAL) + 10'(d)) |-> ##2 s_answer(v);
  endproperty

  AST_PTR: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    s_rd_setup(query_pkg::PTR_LOC) |-> ##2 s_answer(16'h010A))
    else $error("Pointer location gave a wrong value");
  AST_PAGE: assert property (p_entry(query_pkg::D_PAGE, 16'h0003))
    else $error("Page read entry wrong");
  AST_SYNCNUM: assert property (p_entry(query_pkg::D_SYNCNUM, 16'h0004))
    else $error("Synchronous field count wrong");
  AST_SYNC1: assert property (p_entry(query_pkg::D_SYNC1, 16'h0001))
    else $error("First synchronous entry wrong");
  AST_CONT: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (rdcfg_q == 3'h7) |=> (cont_q && len_q == 8'h00))
    else $error("Code seven not continuous");
  AST_LEN: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (rdcfg_q == 3'h2 && $stable(rdcfg_q)) |=> (!cont_q && len_q == 8'h08))
    else $error("Burst length from code two wrong");
  AST_SYNC4: assert property (p_entry(8'h22, 16'h0007))
    else $error("Fourth synchronous entry wrong");
  AST_BANKNUM: assert property (p_entry(query_pkg::D_BANKNUM, 16'h0002))
    else $error("Bank region count wrong");
  AST_BANKCNT: assert property (p_entry(query_pkg::D_BANKCNT, 16'h000F))
    else $error("Identical bank count wrong");
  AST_CONC: assert property (p_entry(query_pkg::D_CONC, 16'h0011))
    else $error("Concurrency entry wrong");
  AST_OTHERS: assert property (p_entry(query_pkg::D_OTHERS, 16'h0000))
    else $error("Other bank activity entry wrong");
  AST_OTHPRG: assert property (p_entry(query_pkg::D_OTHPRG, 16'h0000))
    else $error("Other bank activity while programming entry wrong");
  AST_BLKTYP: assert property (p_entry(query_pkg::D_BLKTYP, 16'h0001))
    else $error("Erase block type count wrong");
  AST_BLKDSC: assert property (p_entry(query_pkg::D_BLKDSC, 16'h0007))
    else $error("Block descriptor low byte wrong");
  AST_ENDUR: assert property (p_entry(query_pkg::D_ENDUR, 16'h0064))
    else $error("Endurance entry wrong");
  AST_CELL: assert property (p_entry(query_pkg::D_CELL, 16'h0001))
    else $error("Cell entry wrong");
  AST_MODE: assert property (p_entry(query_pkg::D_MODE, 16'h0003))
    else $error("Mode capability entry wrong");
  AST_WRREF: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (PSEL_IN && !PENABLE_IN && PWRITE_IN && state_q == ST_IDLE
      && PADDR_IN[11:2] == 10'h127) |-> ##2 (PREADY_OUT && PSLVERR_OUT))
    else $error("Write to a query entry not refused");
  AST_UPPER: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    (PREADY_OUT && qry_ok_q) |-> (PRDATA_OUT[31:16] == 16'h0000))
    else $error("Upper query data bits not zero");

endmodule // query_space

// ==== bench/query_host.sv ====
// Purpose: APB host model that reads and configures the query space
// Assumes: One transfer at a time; caller chains transfers back to back
// Notes:   Request is left standing after the answer; the next setup replaces it
module query_host (
  input  wire logic        clk_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [11:0] paddr_out,
  output logic      [31:0] pwdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int hung = 0;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
  end
  // Bounded wait, so a silent slave cannot hang the run
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= wd;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 20);
    rd = prdata_in;
    err = pslverr_in;
    if (pready_in !== 1'b1) hung++;
  endtask
  task automatic set_burst(input logic [31:0] cap, output logic err);
    logic [31:0] rd;
    xfer(1'b1, {query_pkg::IDX_RDCFG, 2'b00}, {29'h0, cap[2:0]}, rd, err);
  endtask
  task automatic idle();
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    @(posedge clk_in);
  endtask
endmodule // query_host

// ==== bench/query_space_test.sv ====
// Purpose: Self-checking bench for the query space slave
// Assumes: One wait state APB slave, own registers at 7C0h..7C8h
// Notes:   Expected entries are written out here, not taken from the package
module query_space_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          n_errors = 0;
  int          checks   = 0;
  logic [15:0] exp_tab [21] = '{16'h0003, 16'h0004, 16'h0001, 16'h0002, 16'h0003,
    16'h0007, 16'h0002, 16'h000F, 16'h0000, 16'h0011, 16'h0000, 16'h0000, 16'h0001,
    16'h0007, 16'h0000, 16'h0000, 16'h0002, 16'h0064, 16'h0000, 16'h0001, 16'h0003};
  always #50 clock = ~clock;
  query_space i_query_space (.CLOCK_IN(clock), .RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
  query_host i_query_host (.clk_in(clock), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic exp_err, output logic [31:0] rd);
    logic err;
    i_query_host.xfer(wr, a, wd, rd, err);
    if (i_query_host.hung != 0) begin
      n_errors++;
      summarize();
    end
    chk("slverr", {31'h0, exp_err}, {31'h0, err});
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, exp_err, rd);
    chk(what, exp, rd);
  endtask
  task automatic t_entries();
    rd_chk("pointer", 12'h054, 32'h0000_010A, 1'b0);
    for (int i = 0; i < 21; i++) begin
      rd_chk("entry", 12'h49C + 12'(4 * i), {16'h0, exp_tab[i]}, 1'b0);
    end
    $display("t_entries done");
  endtask
  task automatic t_refuse();
    logic [31:0] rd;
    bus(1'b1, 12'h49C, 32'hFFFF_FFFF, 1'b1, rd);
    bus(1'b1, 12'h4A4, 32'h0000_0000, 1'b1, rd);
    rd_chk("unmapped", 12'h000, 32'h0, 1'b1);
    bus(1'b1, 12'h7C8, 32'h0000_FFFF, 1'b1, rd);
    rd_chk("page after write", 12'h49C, 32'h0000_0003, 1'b0);
    rd_chk("sync1 after write", 12'h4A4, 32'h0000_0001, 1'b0);
    bus(1'b1, 12'h7C0, 32'h0, 1'b0, rd);
    rd_chk("disabled read", 12'h49C, 32'h0, 1'b1);
    bus(1'b1, 12'h7C0, 32'h1, 1'b0, rd);
    rd_chk("enabled read", 12'h49C, 32'h0000_0003, 1'b0);
    $display("t_refuse done");
  endtask
  task automatic t_burst();
    logic [31:0] cap, rd;
    logic        err;
    rd_chk("rdcfg reset", 12'h7C4, 32'h0000_0007, 1'b0);
    bus(1'b0, 12'h4A4, 32'h0, 1'b0, cap);
    i_query_host.set_burst(cap, err);
    chk("set_burst err", 32'h0, {31'h0, err});
    rd_chk("rdcfg code", 12'h7C4, 32'h0000_0001, 1'b0);
    bus(1'b0, 12'h7C8, 32'h0, 1'b0, rd);
    chk("burst length", {23'h0, 8'd4, 1'b0}, {23'h0, rd[24:16]});
    chk("read count", 32'h0000_001A, {16'h0, rd[15:0]});
    bus(1'b0, 12'h4A8, 32'h0, 1'b0, cap);
    i_query_host.set_burst(cap, err);
    chk("set_burst err", 32'h0, {31'h0, err});
    bus(1'b0, 12'h7C8, 32'h0, 1'b0, rd);
    chk("burst eight", {23'h0, 8'd8, 1'b0}, {23'h0, rd[24:16]});
    bus(1'b0, 12'h4B0, 32'h0, 1'b0, cap);
    i_query_host.set_burst(cap, err);
    bus(1'b0, 12'h7C8, 32'h0, 1'b0, rd);
    chk("continuous", {23'h0, 9'h001}, {23'h0, rd[24:16]});
    $display("t_burst done");
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_entries();
    t_refuse();
    t_burst();
    i_query_host.idle();
    summarize();
  end
endmodule // query_space_test
